// ### design/ogc_bank.sv
`timescale 1ns/1ns
// Overview of operation
// R1: Bit 15 of each channel register turns that output driver on when set and resets to off.
// R2: Bit 14 of each channel register mutes that channel when set and resets to unmuted.
// R3: Bit 13 picks gain timing, zero applying a new gain at once and one waiting for a zero crossing.
// R4: Written volumes stay pending until a one is written to bit 8 of either register of the pair, then both update.
// R5: Bits 7:2 hold the six-bit volume code, from -57dB at 000000 through 0dB at 111001 to +6dB, reset 111001.
// R6: Bit 10 of the second pair right register turns on its inverting amplifier, reset off.
// R7: Bit 9 of the second pair right register steers the gain stage to the driver when set, else to the inverter, reset 1.
// R8: Software sets the inverter on with steering low for the inverting path, and the reverse for the non-inverting one.
// R9: A one in a pair update bit is a strobe moving both pending codes into the active gains in the same cycle.
module ogc_bank
   import ogc_pkg::*;
(
   input  wire  logic                  core_clk,
   input  wire  logic                  rstn,
   input  wire  logic [OGC_ADDR_W-1:0] reg_addr,
   input  wire  logic [OGC_DATA_W-1:0] reg_wdata,
   input  wire  logic                  reg_wr,
   input  wire  logic                  reg_rd,
   input  wire  logic [OGC_CH_N-1:0]   zero_cross_seen,
   output logic [OGC_DATA_W-1:0]       reg_rdata_ff,
   output logic                        pair_a_left_drive_on,
   output logic                        pair_a_right_drive_on,
   output logic                        pair_b_left_drive_on,
   output logic                        pair_b_right_drive_on,
   output logic                        pair_a_left_silence,
   output logic                        pair_a_right_silence,
   output logic                        pair_b_left_silence,
   output logic                        pair_b_right_silence,
   output logic                        pair_a_left_zero_cross_sel,
   output logic                        pair_a_right_zero_cross_sel,
   output logic                        pair_b_left_zero_cross_sel,
   output logic                        pair_b_right_zero_cross_sel,
   output logic [OGC_GAIN_W-1:0]       pair_a_left_gain_code,
   output logic [OGC_GAIN_W-1:0]       pair_a_right_gain_code,
   output logic [OGC_GAIN_W-1:0]       pair_b_left_gain_code,
   output logic [OGC_GAIN_W-1:0]       pair_b_right_gain_code,
   output logic                        pair_b_right_invert_amp_on,
   output logic                        pair_b_right_path_steer
);
   localparam logic [7:0] CH_OFS [OGC_CH_N] = '{OGC_OFS_A_L, OGC_OFS_A_R, OGC_OFS_B_L, OGC_OFS_B_R};

   logic [OGC_CH_N-1:0]   wr_hit;
   logic                  pair_a_gain_commit;
   logic                  pair_b_gain_commit;
   logic [OGC_CH_N-1:0]   ch_commit;
   logic [OGC_CH_N-1:0]   ch_on;
   logic [OGC_CH_N-1:0]   ch_sil;
   logic [OGC_CH_N-1:0]   ch_zc;
   logic [OGC_GAIN_W-1:0] ch_pend   [OGC_CH_N];
   logic [OGC_GAIN_W-1:0] ch_active [OGC_CH_N];
   logic [OGC_GAIN_W-1:0] ch_apply  [OGC_CH_N];
   logic                  inv_ff;
   logic                  steer_ff;
   logic [OGC_DATA_W-1:0] nxt_rdata;
   logic [OGC_DATA_W-1:0] reg_wdata_q;

   // ==========================================
   // Address decode and pair strobes
   always_comb
   begin
      for (int i = 0; i < OGC_CH_N; i++)
         wr_hit[i] = reg_wr && (reg_addr == CH_OFS[i]);
      pair_a_gain_commit = (wr_hit[0] || wr_hit[1]) && reg_wdata[OGC_BIT_COMMIT]; // R4 R9
      pair_b_gain_commit = (wr_hit[2] || wr_hit[3]) && reg_wdata[OGC_BIT_COMMIT]; // R4 R9
      ch_commit = {pair_b_gain_commit, pair_b_gain_commit, pair_a_gain_commit, pair_a_gain_commit};
   end

   // ==========================================
   // Channel slices
   genvar g;
   generate
      for (g = 0; g < OGC_CH_N; g++)
      begin : g_ch
         ogc_channel u_ch
         (
            .core_clk        (core_clk),
            .rstn            (rstn),
            .wr_en           (wr_hit[g]),
            .wdata           (reg_wdata),
            .commit          (ch_commit[g]),
            .zc_event        (zero_cross_seen[g]),
            .drive_on_ff     (ch_on[g]),
            .silence_ff      (ch_sil[g]),
            .zc_sel_ff       (ch_zc[g]),
            .pend_code_ff    (ch_pend[g]),
            .active_code_ff  (ch_active[g]),
            .applied_code_ff (ch_apply[g])
         );
      end
   endgenerate

   // ==========================================
   // Second pair right path control
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         inv_ff   <= OGC_INV_RST;
         steer_ff <= OGC_STEER_RST;
      end
      else if (wr_hit[3])
      begin
         inv_ff   <= reg_wdata[OGC_BIT_INV];   // R6 R8
         steer_ff <= reg_wdata[OGC_BIT_STEER]; // R7 R8
      end
   end

   // ==========================================
   // Read back
   always_comb
   begin
      nxt_rdata = OGC_RD_ZERO;
      for (int i = 0; i < OGC_CH_N; i++)
      begin
         if (reg_addr == CH_OFS[i])
         begin
            nxt_rdata[OGC_BIT_ON]                = ch_on[i];
            nxt_rdata[OGC_BIT_SIL]               = ch_sil[i];
            nxt_rdata[OGC_BIT_ZC]                = ch_zc[i];
            nxt_rdata[OGC_GAIN_HI:OGC_GAIN_LO]   = ch_pend[i];
         end
      end
      if (reg_addr == OGC_OFS_B_R)
      begin
         nxt_rdata[OGC_BIT_INV]   = inv_ff;
         nxt_rdata[OGC_BIT_STEER] = steer_ff;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata_ff <= OGC_RD_ZERO;
      else if (reg_rd)
         reg_rdata_ff <= nxt_rdata;
   end

   // ==========================================
   // Outputs
   assign pair_a_left_drive_on        = ch_on[0];
   assign pair_a_right_drive_on       = ch_on[1];
   assign pair_b_left_drive_on        = ch_on[2];
   assign pair_b_right_drive_on       = ch_on[3];
   assign pair_a_left_silence         = ch_sil[0];
   assign pair_a_right_silence        = ch_sil[1];
   assign pair_b_left_silence         = ch_sil[2];
   assign pair_b_right_silence        = ch_sil[3];
   assign pair_a_left_zero_cross_sel  = ch_zc[0];
   assign pair_a_right_zero_cross_sel = ch_zc[1];
   assign pair_b_left_zero_cross_sel  = ch_zc[2];
   assign pair_b_right_zero_cross_sel = ch_zc[3];
   assign pair_a_left_gain_code       = ch_apply[0];
   assign pair_a_right_gain_code      = ch_apply[1];
   assign pair_b_left_gain_code       = ch_apply[2];
   assign pair_b_right_gain_code      = ch_apply[3];
   assign pair_b_right_invert_amp_on  = inv_ff;
   assign pair_b_right_path_steer     = steer_ff;

   // ==========================================
   // Checks
   AST_PAIR_A_TOGETHER: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      (wr_hit[0] && reg_wdata[OGC_BIT_COMMIT])
      |=> ch_active[0] == reg_wdata_q[OGC_GAIN_HI:OGC_GAIN_LO] && ch_active[1] == $past(ch_pend[1]))
      else $error("pair A did not update together");
   AST_PAIR_B_TOGETHER: assert property (@(posedge core_clk) disable iff (!rstn) // R9
      (wr_hit[2] && reg_wdata[OGC_BIT_COMMIT])
      |=> ch_active[2] == reg_wdata_q[OGC_GAIN_HI:OGC_GAIN_LO] && ch_active[3] == $past(ch_pend[3]))
      else $error("pair B did not update together");
   AST_INV_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // R6
      wr_hit[3] |=> pair_b_right_invert_amp_on == $past(reg_wdata[OGC_BIT_INV]))
      else $error("inverter enable not stored");
   AST_STEER_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // R7
      !wr_hit[3] |=> $stable(pair_b_right_path_steer))
      else $error("steering changed without write");

   // ==========================================
   // Pairing, path bit, unmapped write and read back checks
   AST_PAIR_A_RIGHT: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      (wr_hit[1] && reg_wdata[OGC_BIT_COMMIT])
      |=> ch_active[1] == reg_wdata_q[OGC_GAIN_HI:OGC_GAIN_LO] && ch_active[0] == $past(ch_pend[0]))
      else $error("pair A right commit did not update both");
   AST_PAIR_B_RIGHT: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      (wr_hit[3] && reg_wdata[OGC_BIT_COMMIT])
      |=> ch_active[3] == reg_wdata_q[OGC_GAIN_HI:OGC_GAIN_LO] && ch_active[2] == $past(ch_pend[2]))
      else $error("pair B right commit did not update both");
   AST_PAIR_A_ONLY: assert property (@(posedge core_clk) disable iff (!rstn) // R9
      pair_a_gain_commit |=> $stable(ch_active[2]) && $stable(ch_active[3]))
      else $error("pair A commit moved pair B gain");
   AST_PAIR_B_ONLY: assert property (@(posedge core_clk) disable iff (!rstn) // R9
      pair_b_gain_commit |=> $stable(ch_active[0]) && $stable(ch_active[1]))
      else $error("pair B commit moved pair A gain");
   AST_STEER_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // R7
      wr_hit[3] |=> pair_b_right_path_steer == $past(reg_wdata[OGC_BIT_STEER]))
      else $error("steering bit not stored");
   AST_INV_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // R6
      !wr_hit[3] |=> $stable(pair_b_right_invert_amp_on))
      else $error("inverter enable changed without write");
   AST_RD_VOL: assert property (@(posedge core_clk) disable iff (!rstn) // R5
      (reg_rd && reg_addr == OGC_OFS_A_L) |=> reg_rdata_ff[OGC_GAIN_HI:OGC_GAIN_LO] == $past(ch_pend[0]))
      else $error("volume read back wrong");
   AST_RD_ON: assert property (@(posedge core_clk) disable iff (!rstn) // R1 R2
      (reg_rd && reg_addr == OGC_OFS_B_R)
      |=> reg_rdata_ff[OGC_BIT_ON] == $past(ch_on[3]) && reg_rdata_ff[OGC_BIT_SIL] == $past(ch_sil[3]))
      else $error("enable or mute read back wrong");
   AST_RD_PATH_BITS: assert property (@(posedge core_clk) disable iff (!rstn) // R6 R7
      (reg_rd && reg_addr != OGC_OFS_B_R) |=> reg_rdata_ff[OGC_BIT_INV:OGC_BIT_STEER] == 2'h0)
      else $error("path bits read back outside their register");
   AST_RD_COMMIT_ZERO: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      reg_rd |=> !reg_rdata_ff[OGC_BIT_COMMIT])
      else $error("update bit read back as one");
   AST_UNMAPPED_WR: assert property (@(posedge core_clk) disable iff (!rstn) // R1 R2 R3
      (reg_wr && !(|wr_hit)) |=> $stable(ch_on) && $stable(ch_sil) && $stable(ch_zc))
      else $error("unmapped write changed a control bit");
   AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // R5
      !reg_rd |=> $stable(reg_rdata_ff))
      else $error("read data changed without read");

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         reg_wdata_q <= OGC_RD_ZERO;
      else
         reg_wdata_q <= reg_wdata;
   end
endmodule

// ### design/ogc_pkg.sv
package ogc_pkg;
   // ==========================================
   // Register map
   localparam int          OGC_ADDR_W   = 8;
   localparam int          OGC_DATA_W   = 16;
   localparam int          OGC_GAIN_W   = 6;
   localparam int          OGC_CH_N     = 4;
   localparam logic [7:0]  OGC_OFS_A_L  = 8'h68;
   localparam logic [7:0]  OGC_OFS_A_R  = 8'h69;
   localparam logic [7:0]  OGC_OFS_B_L  = 8'h6a;
   localparam logic [7:0]  OGC_OFS_B_R  = 8'h6b;
   // ==========================================
   // Field positions
   localparam int          OGC_BIT_ON     = 15;
   localparam int          OGC_BIT_SIL    = 14;
   localparam int          OGC_BIT_ZC     = 13;
   localparam int          OGC_BIT_INV    = 10;
   localparam int          OGC_BIT_STEER  = 9;
   localparam int          OGC_BIT_COMMIT = 8;
   localparam int          OGC_GAIN_HI    = 7;
   localparam int          OGC_GAIN_LO    = 2;
   // ==========================================
   // Reset values
   localparam logic [5:0]  OGC_GAIN_RST   = 6'h39;
   localparam logic        OGC_ON_RST     = 1'h0;
   localparam logic        OGC_SIL_RST    = 1'h0;
   localparam logic        OGC_ZC_RST     = 1'h0;
   localparam logic        OGC_INV_RST    = 1'h0;
   localparam logic        OGC_STEER_RST  = 1'h1;
   localparam logic [15:0] OGC_RD_ZERO    = 16'h0000;
endpackage

// ### design/ogc_channel.sv
`timescale 1ns/1ns
module ogc_channel
   import ogc_pkg::*;
(
   input  wire  logic                  core_clk,
   input  wire  logic                  rstn,
   input  wire  logic                  wr_en,
   input  wire  logic [OGC_DATA_W-1:0] wdata,
   input  wire  logic                  commit,
   input  wire  logic                  zc_event,
   output logic                        drive_on_ff,
   output logic                        silence_ff,
   output logic                        zc_sel_ff,
   output logic [OGC_GAIN_W-1:0]       pend_code_ff,
   output logic [OGC_GAIN_W-1:0]       active_code_ff,
   output logic [OGC_GAIN_W-1:0]       applied_code_ff
);
   logic [OGC_GAIN_W-1:0] nxt_active_code;

   // ==========================================
   // Control bits
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         drive_on_ff <= OGC_ON_RST;
         silence_ff  <= OGC_SIL_RST;
         zc_sel_ff   <= OGC_ZC_RST;
      end
      else if (wr_en)
      begin
         drive_on_ff <= wdata[OGC_BIT_ON];  // R1
         silence_ff  <= wdata[OGC_BIT_SIL]; // R2
         zc_sel_ff   <= wdata[OGC_BIT_ZC];  // R3
      end
   end

   // ==========================================
   // Pending gain
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         pend_code_ff <= OGC_GAIN_RST;
      else if (wr_en)
         pend_code_ff <= wdata[OGC_GAIN_HI:OGC_GAIN_LO]; // R5
   end

   // ==========================================
   // Committed gain
   always_comb
   begin
      nxt_active_code = wr_en ? wdata[OGC_GAIN_HI:OGC_GAIN_LO] : pend_code_ff;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         active_code_ff <= OGC_GAIN_RST;
      else if (commit)
         active_code_ff <= nxt_active_code; // R4 R9
   end

   // ==========================================
   // Applied gain, immediate or on zero cross
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         applied_code_ff <= OGC_GAIN_RST;
      else if (!zc_sel_ff || zc_event)
         applied_code_ff <= active_code_ff; // R3
   end

   // ==========================================
   // Checks
   AST_ON_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // R1
      wr_en |=> drive_on_ff == $past(wdata[OGC_BIT_ON]))
      else $error("enable bit not stored");
   AST_SIL_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // R2
      wr_en |=> silence_ff == $past(wdata[OGC_BIT_SIL]))
      else $error("mute bit not stored");
   AST_VOL_STORE: assert property (@(posedge core_clk) disable iff (!rstn) // R5
      wr_en |=> pend_code_ff == $past(wdata[OGC_GAIN_HI:OGC_GAIN_LO]))
      else $error("volume code not stored");
   AST_HOLD_PENDING: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      !commit |=> $stable(active_code_ff))
      else $error("gain changed without commit");
   AST_COMMIT_LOAD: assert property (@(posedge core_clk) disable iff (!rstn) // R9
      commit |=> active_code_ff == $past(nxt_active_code))
      else $error("commit did not load gain");
   AST_IMMEDIATE: assert property (@(posedge core_clk) disable iff (!rstn) // R3
      !zc_sel_ff |=> applied_code_ff == $past(active_code_ff))
      else $error("immediate gain not applied");
   AST_ZC_WAIT: assert property (@(posedge core_clk) disable iff (!rstn) // R3
      (zc_sel_ff && !zc_event) |=> $stable(applied_code_ff))
      else $error("gain changed before zero cross");
endmodule

// ### tb/ogc_testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   import ogc_pkg::*;
   // ==========================================
   // Signals and model state
   logic                  core_clk, rstn, reg_wr, reg_rd;
   logic [OGC_ADDR_W-1:0] reg_addr, ra;
   logic [OGC_DATA_W-1:0] reg_wdata;
   logic [OGC_CH_N-1:0]   zero_cross_seen, m_on, m_sil, m_zc;
   wire  [OGC_DATA_W-1:0] reg_rdata_ff;
   wire  [3:0]            on_o, sil_o, zc_o;
   wire  [23:0]           g_o;
   wire                   inv_o, steer_o;
   logic [5:0]            m_pend [4], m_act [4], m_app [4];
   logic                  m_inv, m_steer;
   logic [31:0]           lfsr, r;
   int                    err_total, total_checks, cyc;
   ogc_bank dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .zero_cross_seen(zero_cross_seen), .reg_rdata_ff(reg_rdata_ff),
      .pair_a_left_drive_on(on_o[0]), .pair_a_right_drive_on(on_o[1]), .pair_b_left_drive_on(on_o[2]),
      .pair_b_right_drive_on(on_o[3]), .pair_a_left_silence(sil_o[0]), .pair_a_right_silence(sil_o[1]),
      .pair_b_left_silence(sil_o[2]), .pair_b_right_silence(sil_o[3]),
      .pair_a_left_zero_cross_sel(zc_o[0]), .pair_a_right_zero_cross_sel(zc_o[1]),
      .pair_b_left_zero_cross_sel(zc_o[2]), .pair_b_right_zero_cross_sel(zc_o[3]),
      .pair_a_left_gain_code(g_o[5:0]), .pair_a_right_gain_code(g_o[11:6]),
      .pair_b_left_gain_code(g_o[17:12]), .pair_b_right_gain_code(g_o[23:18]),
      .pair_b_right_invert_amp_on(inv_o), .pair_b_right_path_steer(steer_o));
   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [15:0] exp_rd(input logic [7:0] a);
      logic [1:0] ch;
      ch = a[1:0];
      if (a < OGC_OFS_A_L || a > OGC_OFS_B_R)
         return 16'h0000;
      return {m_on[ch], m_sil[ch], m_zc[ch], 2'b00, (ch == 2'h3) ? {m_inv, m_steer} : 2'b00, 1'b0, m_pend[ch], 2'b00};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [1:0] ch;
      ch = a[1:0];
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge core_clk);
      #1 reg_wr = 1'b0;
      @(posedge core_clk);
      #1;
      if (a >= OGC_OFS_A_L && a <= OGC_OFS_B_R)
      begin
         {m_on[ch], m_sil[ch], m_zc[ch], m_pend[ch]} = {d[15:13], d[7:2]};
         if (ch == 2'h3)
            {m_inv, m_steer} = d[10:9];
         if (d[8])
            for (int i = 0; i < 2; i++)
               m_act[{ch[1], i[0]}] = m_pend[{ch[1], i[0]}];
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic [15:0] e;
      e = exp_rd(a);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge core_clk);
      #1 reg_rd = 1'b0;
      `CHK("rdata", e, reg_rdata_ff)
      @(posedge core_clk);
      #1;
   endtask
   task automatic settle(input logic [3:0] zmask);
      repeat (2) @(posedge core_clk);
      #1 zero_cross_seen = zmask;
      @(posedge core_clk);
      #1 zero_cross_seen = 4'h0;
      @(posedge core_clk);
      #1;
      for (int i = 0; i < 4; i++)
         if (!m_zc[i] || zmask[i])
            m_app[i] = m_act[i];
      check_all();
   endtask
   task automatic check_all();
      `CHK("drive_on", m_on, on_o)
      `CHK("silence", m_sil, sil_o)
      `CHK("zero_cross_sel", m_zc, zc_o)
      `CHK("invert_amp_on", m_inv, inv_o)
      `CHK("path_steer", m_steer, steer_o)
      for (int i = 0; i < 4; i++)
         `CHK("gain_code", m_app[i], g_o[i*6 +: 6])
   endtask
   task automatic test_done();
      if (err_total == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================
   // Clock and timeout
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         err_total++;
         test_done();
      end
   end
   // ==========================================
   // Main sequence
   initial
   begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, zero_cross_seen} = 31'h0;
      lfsr = 32'h7520;
      {m_on, m_sil, m_zc, m_inv, m_steer} = {12'h000, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++)
         {m_pend[i], m_act[i], m_app[i]} = {3{6'h39}};
      repeat (12) @(posedge core_clk);
      #1 rstn = 1'b1;
      @(posedge core_clk);
      #1 check_all();
      for (int i = 0; i < 4; i++)
         rd(OGC_OFS_A_L + 8'(i));
      wr(OGC_OFS_A_L, 16'h80e4);
      settle(4'h0);
      wr(OGC_OFS_A_R, 16'h4300);
      wr(OGC_OFS_B_R, 16'h24fc);
      settle(4'h0);
      wr(OGC_OFS_B_L, 16'h0100);
      settle(4'h0);
      settle(4'h8);
      wr(8'h6c, 16'hffff);
      settle(4'h0);
      rd(8'h6c);
      rd(8'h67);
      for (int n = 0; n < 300; n++)
      begin
         r = rnd();
         ra = (r[4:2] == 3'h0) ? r[31:24] : OGC_OFS_A_L + {6'h00, r[1:0]};
         wr(ra, 16'(rnd() >> 8));
         settle(4'(rnd() >> 20));
         rd(ra);
      end
      test_done();
   end
endmodule
